// File: logic/act_compute_regs.sv
// Purpose: compute and threshold register set of a converter, AXI4-Lite
// Assumes: converter start/done pulses come from logic on mclk_i
// Notes: registers are byte wide, data in wdata/rdata bits 7:0
//
// Notes on behaviour
// (R1) Each threshold check compares the error against both thresholds.
// (R2) Irq select field decides whether the comparison raises the irq.
// (R3) Lower and upper thresholds: 16-bit signed, read/write, reset zero.
// (R4) Error: read-only 16-bit signed, method picked by error select.
// (R5) Setpoint: 16-bit signed RW, reset zero, used by some methods only.
// (R6) Accumulate/average/burst: filter output is accumulator shifted right.
// (R7) Low-pass mode: filter output is the low-pass result instead.
// (R8) Accumulator is 18-bit signed; top byte upper bits copy the sign.
// (R9) Accumulator writes accepted only while no conversion runs.
// (R10) Repeat modes count triggers; check happens when count hits target.
// (R11) Repeat target sets triggers needed before the threshold check.
// (R12) Repeat counter has no reset; it survives ordinary resets.
// (R13) Previous source 1: previous takes filter output at conversion start.
// (R14) Previous source 0: previous takes the aligned result at start.
// (R15) Result right-aligned when alignment is 1, left-aligned when 0.
// (R16) Every 16-bit register has separate low and high byte registers.
// (R17) Accumulator has an extra upper byte holding bits 17 and 16.
// (R18) Irq select: never, below, at/above lower, between, outside, ...
// (R19) Above flag: error over upper; below flag: error under lower.
// (R20) Bytes sit low to high at consecutive increasing indexes.
`timescale 1ns/1ns
module act_compute_regs (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire act_pkg::act_axil_req_type axi_req_i,
    output act_pkg::act_axil_rsp_type axi_rsp_o,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_result_i,
    output logic conv_active_o,
    output logic threshold_irq_flag_o
);
    // index match for one aligned word slot
    function automatic logic idx_hit(input logic [11:0] addr,
                                     input logic [9:0] idx);
        idx_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
    endfunction

    // signed arithmetic shift of an 18-bit value
    function automatic logic [17:0] sra18(input logic [17:0] v,
                                          input logic [2:0] sh);
        sra18 = $unsigned($signed(v) >>> sh);
    endfunction

    // register state
    logic [15:0] lower_threshold_reg;
    logic [15:0] upper_threshold_reg;
    logic [15:0] setpoint_value_reg;
    logic [15:0] setpoint_error_reg;
    logic [15:0] lpf_reg;
    logic [17:0] accumulator_value_reg;
    logic [7:0] repeat_counter_reg;
    logic [7:0] repeat_target_reg;
    logic [15:0] previous_result_reg;
    logic [15:0] sample_result_reg;
    logic [7:0] cfg0_reg;
    logic [7:0] cfg1_reg;
    logic below_lower_flag_reg;
    logic above_upper_flag_reg;
    logic threshold_irq_flag_reg;
    logic busy_reg;
    logic check_reg;
    logic compare_reg;
    logic acc_clear_reg;

    // bus state
    logic aw_hold_reg;
    logic [11:0] aw_addr_reg;
    logic w_hold_reg;
    logic [7:0] w_data_reg;
    logic w_lane0_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [7:0] rdata_reg;
    logic [1:0] rresp_reg;

    // configuration fields
    wire [2:0] threshold_irq_select = cfg0_reg[act_pkg::CFG0_TMD_LSB +: 3];
    wire [2:0] error_select_a = cfg0_reg[act_pkg::CFG0_ERROR_SELECT_A_LSB +: 3];
    wire [2:0] shift_select = cfg1_reg[act_pkg::CFG1_SHIFT_LSB +: 3];
    wire previous_source_select = cfg1_reg[act_pkg::CFG1_PSRC_BIT];
    wire result_alignment = cfg1_reg[act_pkg::CFG1_ALIGN_BIT];
    wire [2:0] mode = cfg1_reg[act_pkg::CFG1_MODE_LSB +: 3];
    wire mode_lpf = (mode == act_pkg::MODE_LPF);
    wire mode_clears = (mode == act_pkg::MODE_AVERAGE) ||
        (mode == act_pkg::MODE_BURST);
    wire mode_repeat = mode_lpf || mode_clears;

    // write channel decode
    wire aw_take = axi_req_i.awvalid && !aw_hold_reg;
    wire w_take = axi_req_i.wvalid && !w_hold_reg;
    wire wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire wr_en = wr_go && w_lane0_reg;
    wire wr_lth_l = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_LTH_L);
    wire wr_lth_h = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_LTH_H);
    wire wr_uth_l = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_UTH_L);
    wire wr_uth_h = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_UTH_H);
    wire wr_stpt_l = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_STPT_L);
    wire wr_stpt_h = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_STPT_H);
    wire wr_acc_ok = wr_en && !busy_reg;
    wire wr_acc_l = wr_acc_ok && idx_hit(aw_addr_reg, act_pkg::IDX_ACC_L);
    wire wr_acc_h = wr_acc_ok && idx_hit(aw_addr_reg, act_pkg::IDX_ACC_H);
    wire wr_acc_u = wr_acc_ok && idx_hit(aw_addr_reg, act_pkg::IDX_ACC_U);
    wire wr_cnt = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_CNT);
    wire wr_rpt = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_RPT);
    wire wr_res_l = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_RES_L);
    wire wr_res_h = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_RES_H);
    wire wr_cfg0 = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_CFG0);
    wire wr_cfg1 = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_CFG1);
    wire wr_stat = wr_en && idx_hit(aw_addr_reg, act_pkg::IDX_STAT);
    wire tif_clear = wr_stat && w_data_reg[act_pkg::STAT_TIF_BIT];

    // conversion events
    wire start_ev = conv_start_i && !busy_reg;
    wire done_ev = conv_done_i && busy_reg;

    // aligned sample and accumulator arithmetic
    wire [15:0] aligned = result_alignment ? {4'h0, conv_result_i} :
        {conv_result_i, 4'h0}; // see (R15)
    wire [17:0] sample18 = {6'h00, conv_result_i};
    wire [17:0] acc_base = acc_clear_reg ? 18'h0_0000 :
        accumulator_value_reg;
    wire [17:0] acc_shifted = sra18(accumulator_value_reg, shift_select);
    wire [17:0] acc_lpf = accumulator_value_reg - acc_shifted + sample18;
    wire [17:0] acc_next = mode_lpf ? acc_lpf : acc_base + sample18;
    wire [17:0] lpf_delta = {2'h0, aligned} - {{2{lpf_reg[15]}}, lpf_reg};
    wire [17:0] lpf_step = sra18(lpf_delta, shift_select);
    wire [15:0] lpf_next = lpf_reg + lpf_step[15:0];
    // low-pass result replaces the shifted accumulator
    wire [15:0] filter_output = mode_lpf ? lpf_reg :
        acc_shifted[15:0]; // see (R6) (R7)

    // repeat count and check decision
    wire [7:0] cnt_inc = (repeat_counter_reg == 8'hff) ? 8'hff :
        repeat_counter_reg + 8'h01;
    wire count_reached = (cnt_inc >= repeat_target_reg); // see (R10) (R11)
    wire check_now = done_ev && (!mode_repeat || count_reached);

    // error calculation selection
    logic [15:0] error_error_select_a;
    always_comb begin
        case (error_select_a) // see (R4) (R5)
            3'h0: error_error_select_a = sample_result_reg - previous_result_reg;
            3'h1: error_error_select_a = sample_result_reg - setpoint_value_reg;
            3'h2: error_error_select_a = previous_result_reg - filter_output;
            3'h3: error_error_select_a = filter_output - setpoint_value_reg;
            default: error_error_select_a = sample_result_reg - filter_output;
        endcase
    end

    // signed comparisons against both thresholds
    wire below_now = $signed(setpoint_error_reg) <
        $signed(lower_threshold_reg); // see (R1) (R19)
    wire above_now = $signed(setpoint_error_reg) >
        $signed(upper_threshold_reg); // see (R1) (R19)
    logic irq_hit;
    always_comb begin
        case (threshold_irq_select) // see (R2) (R18)
            3'h0: irq_hit = 1'b0;
            3'h1: irq_hit = below_now;
            3'h2: irq_hit = !below_now;
            3'h3: irq_hit = !below_now && !above_now;
            3'h4: irq_hit = below_now || above_now;
            3'h5: irq_hit = !above_now;
            3'h6: irq_hit = above_now;
            default: irq_hit = 1'b1;
        endcase
    end

    // read mux, one byte per index
    wire [9:0] rd_idx = axi_req_i.araddr[11:2];
    wire rd_aligned = (axi_req_i.araddr[1:0] == 2'h0);
    wire [7:0] acc_top = {{6{accumulator_value_reg[17]}},
        accumulator_value_reg[17:16]}; // see (R8) (R17)
    wire [7:0] stat_byte = {4'h0, busy_reg, threshold_irq_flag_reg,
        above_upper_flag_reg, below_lower_flag_reg};
    logic [7:0] rd_byte;
    logic rd_ok;
    always_comb begin
        rd_ok = rd_aligned;
        case (rd_idx) // see (R16) (R20)
            act_pkg::IDX_LTH_L: rd_byte = lower_threshold_reg[7:0];
            act_pkg::IDX_LTH_H: rd_byte = lower_threshold_reg[15:8];
            act_pkg::IDX_UTH_L: rd_byte = upper_threshold_reg[7:0];
            act_pkg::IDX_UTH_H: rd_byte = upper_threshold_reg[15:8];
            act_pkg::IDX_ERR_L: rd_byte = setpoint_error_reg[7:0];
            act_pkg::IDX_ERR_H: rd_byte = setpoint_error_reg[15:8];
            act_pkg::IDX_STPT_L: rd_byte = setpoint_value_reg[7:0];
            act_pkg::IDX_STPT_H: rd_byte = setpoint_value_reg[15:8];
            act_pkg::IDX_FLT_L: rd_byte = filter_output[7:0];
            act_pkg::IDX_FLT_H: rd_byte = filter_output[15:8];
            act_pkg::IDX_ACC_L: rd_byte = accumulator_value_reg[7:0];
            act_pkg::IDX_ACC_H: rd_byte = accumulator_value_reg[15:8];
            act_pkg::IDX_ACC_U: rd_byte = acc_top;
            act_pkg::IDX_CNT: rd_byte = repeat_counter_reg;
            act_pkg::IDX_RPT: rd_byte = repeat_target_reg;
            act_pkg::IDX_PREV_L: rd_byte = previous_result_reg[7:0];
            act_pkg::IDX_PREV_H: rd_byte = previous_result_reg[15:8];
            act_pkg::IDX_RES_L: rd_byte = sample_result_reg[7:0];
            act_pkg::IDX_RES_H: rd_byte = sample_result_reg[15:8];
            act_pkg::IDX_CFG0: rd_byte = cfg0_reg;
            act_pkg::IDX_CFG1: rd_byte = cfg1_reg;
            act_pkg::IDX_STAT: rd_byte = stat_byte;
            default: begin
                rd_byte = act_pkg::RST_BYTE;
                rd_ok = 1'b0;
            end
        endcase
    end

    // write decode validity for the response
    logic wr_known;
    always_comb begin
        case (aw_addr_reg[11:2])
            act_pkg::IDX_ERR_L, act_pkg::IDX_ERR_H,
            act_pkg::IDX_FLT_L, act_pkg::IDX_FLT_H,
            act_pkg::IDX_PREV_L, act_pkg::IDX_PREV_H,
            act_pkg::IDX_LTH_L, act_pkg::IDX_LTH_H,
            act_pkg::IDX_UTH_L, act_pkg::IDX_UTH_H,
            act_pkg::IDX_STPT_L, act_pkg::IDX_STPT_H,
            act_pkg::IDX_ACC_L, act_pkg::IDX_ACC_H, act_pkg::IDX_ACC_U,
            act_pkg::IDX_CNT, act_pkg::IDX_RPT,
            act_pkg::IDX_RES_L, act_pkg::IDX_RES_H,
            act_pkg::IDX_CFG0, act_pkg::IDX_CFG1,
            act_pkg::IDX_STAT: wr_known = (aw_addr_reg[1:0] == 2'h0);
            default: wr_known = 1'b0;
        endcase
    end

    // bus handshake outputs
    assign axi_rsp_o.awready = !aw_hold_reg;
    assign axi_rsp_o.wready = !w_hold_reg;
    assign axi_rsp_o.bvalid = bvalid_reg;
    assign axi_rsp_o.bresp = bresp_reg;
    assign axi_rsp_o.arready = !rvalid_reg;
    assign axi_rsp_o.rvalid = rvalid_reg;
    assign axi_rsp_o.rdata = {24'h00_0000, rdata_reg};
    assign axi_rsp_o.rresp = rresp_reg;
    assign conv_active_o = busy_reg;
    assign threshold_irq_flag_o = threshold_irq_flag_reg;

    // write address and data capture, write response
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_hold_reg <= 1'b0;
            w_data_reg <= act_pkg::RST_BYTE;
            w_lane0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= act_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (aw_take) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= axi_req_i.awaddr;
            end else if (wr_go) begin
                aw_hold_reg <= 1'b0;
            end
            if (w_take) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= axi_req_i.wdata[7:0];
                w_lane0_reg <= axi_req_i.wstrb[0];
            end else if (wr_go) begin
                w_hold_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? act_pkg::RESP_OKAY :
                    act_pkg::RESP_SLVERR;
            end else if (axi_req_i.bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= act_pkg::RST_BYTE;
            rresp_reg <= act_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (axi_req_i.arvalid && !rvalid_reg) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_ok ? rd_byte : act_pkg::RST_BYTE;
                rresp_reg <= rd_ok ? act_pkg::RESP_OKAY :
                    act_pkg::RESP_SLVERR;
            end else if (axi_req_i.rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // software-only registers with defined reset
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            lower_threshold_reg <= act_pkg::RST_WORD16; // see (R3)
            upper_threshold_reg <= act_pkg::RST_WORD16; // see (R3)
            setpoint_value_reg <= act_pkg::RST_WORD16; // see (R5)
            repeat_target_reg <= act_pkg::RST_BYTE;
            cfg0_reg <= act_pkg::RST_BYTE;
            cfg1_reg <= act_pkg::RST_BYTE;
        end else if (ce_i) begin
            if (wr_lth_l) lower_threshold_reg[7:0] <= w_data_reg;
            if (wr_lth_h) lower_threshold_reg[15:8] <= w_data_reg;
            if (wr_uth_l) upper_threshold_reg[7:0] <= w_data_reg;
            if (wr_uth_h) upper_threshold_reg[15:8] <= w_data_reg;
            if (wr_stpt_l) setpoint_value_reg[7:0] <= w_data_reg;
            if (wr_stpt_h) setpoint_value_reg[15:8] <= w_data_reg;
            if (wr_rpt) repeat_target_reg <= w_data_reg; // see (R11)
            if (wr_cfg0) cfg0_reg <= w_data_reg;
            if (wr_cfg1) cfg1_reg <= w_data_reg;
        end
    end

    // conversion tracking and check pipeline
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            busy_reg <= 1'b0;
            check_reg <= 1'b0;
            compare_reg <= 1'b0;
            acc_clear_reg <= 1'b0;
            below_lower_flag_reg <= 1'b0;
            above_upper_flag_reg <= 1'b0;
            threshold_irq_flag_reg <= 1'b0;
            lpf_reg <= act_pkg::RST_WORD16; // filter starts from a known zero
        end else if (ce_i) begin
            if (done_ev && mode_lpf) lpf_reg <= lpf_next; // see (R7)
            if (start_ev) busy_reg <= 1'b1;
            else if (done_ev) busy_reg <= 1'b0;
            check_reg <= check_now;
            compare_reg <= check_reg;
            if (check_now) acc_clear_reg <= mode_clears;
            else if (done_ev) acc_clear_reg <= 1'b0;
            if (compare_reg) begin
                below_lower_flag_reg <= below_now; // see (R1) (R19)
                above_upper_flag_reg <= above_now; // see (R1) (R19)
            end
            // a new hit wins over a software clear
            if (compare_reg && irq_hit) begin
                threshold_irq_flag_reg <= 1'b1; // see (R2)
            end else if (tif_clear) begin
                threshold_irq_flag_reg <= 1'b0;
            end
        end
    end

    // data registers: undefined at power-up, kept across system reset
    always_ff @(posedge mclk_i) begin
        if (ce_i) begin
            if (check_reg) setpoint_error_reg <= error_error_select_a; // see (R4)
            if (done_ev) begin
                accumulator_value_reg <= acc_next;
            end else begin
                if (wr_acc_l) begin
                    accumulator_value_reg[7:0] <= w_data_reg; // see (R9)
                end
                if (wr_acc_h) begin
                    accumulator_value_reg[15:8] <= w_data_reg; // see (R9)
                end
                if (wr_acc_u) begin // see (R9) (R17)
                    accumulator_value_reg[17:16] <= w_data_reg[1:0];
                end
            end
            if (done_ev && mode_repeat) begin
                repeat_counter_reg <= (check_now && mode_clears) ? 8'h00 :
                    cnt_inc; // see (R10) (R12)
            end else if (wr_cnt) begin
                repeat_counter_reg <= w_data_reg;
            end
            if (start_ev) begin
                previous_result_reg <= previous_source_select ?
                    filter_output : sample_result_reg; // see (R13) (R14)
            end
            if (done_ev) begin
                sample_result_reg <= aligned; // see (R15)
            end else begin
                if (wr_res_l) sample_result_reg[7:0] <= w_data_reg;
                if (wr_res_h) sample_result_reg[15:8] <= w_data_reg;
            end
        end
    end
endmodule // act_compute_regs

// File: pkg/act_pkg.sv
// Purpose: constants and carrier types for the compute and threshold set
// Assumes: byte registers, each at byte address four times its index
// Notes: indexes are word slots on the AXI4-Lite bus
package act_pkg;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    // register indexes, one byte each
    localparam logic [9:0] IDX_LTH_L = 10'h08c;
    localparam logic [9:0] IDX_LTH_H = 10'h08d;
    localparam logic [9:0] IDX_UTH_L = 10'h08e;
    localparam logic [9:0] IDX_UTH_H = 10'h08f;
    localparam logic [9:0] IDX_ERR_L = 10'h090;
    localparam logic [9:0] IDX_ERR_H = 10'h091;
    localparam logic [9:0] IDX_STPT_L = 10'h092;
    localparam logic [9:0] IDX_STPT_H = 10'h093;
    localparam logic [9:0] IDX_FLT_L = 10'h094;
    localparam logic [9:0] IDX_FLT_H = 10'h095;
    localparam logic [9:0] IDX_ACC_L = 10'h096;
    localparam logic [9:0] IDX_ACC_H = 10'h097;
    localparam logic [9:0] IDX_ACC_U = 10'h098;
    localparam logic [9:0] IDX_CNT = 10'h099;
    localparam logic [9:0] IDX_RPT = 10'h09a;
    localparam logic [9:0] IDX_PREV_L = 10'h09b;
    localparam logic [9:0] IDX_PREV_H = 10'h09c;
    localparam logic [9:0] IDX_RES_L = 10'h09d;
    localparam logic [9:0] IDX_RES_H = 10'h09e;
    localparam logic [9:0] IDX_CFG0 = 10'h0a0;
    localparam logic [9:0] IDX_CFG1 = 10'h0a1;
    localparam logic [9:0] IDX_STAT = 10'h0a2;
    // cfg0: irq select [2:0], error select [6:4]
    localparam int CFG0_TMD_LSB = 0;
    localparam int CFG0_ERROR_SELECT_A_LSB = 4;
    // cfg1: shift [2:0], previous source [3], alignment [4], mode [7:5]
    localparam int CFG1_SHIFT_LSB = 0;
    localparam int CFG1_PSRC_BIT = 3;
    localparam int CFG1_ALIGN_BIT = 4;
    localparam int CFG1_MODE_LSB = 5;
    // status bits
    localparam int STAT_BELOW_BIT = 0;
    localparam int STAT_ABOVE_BIT = 1;
    localparam int STAT_TIF_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    // computation mode codes
    localparam logic [2:0] MODE_BASIC = 3'h0;
    localparam logic [2:0] MODE_ACCUM = 3'h1;
    localparam logic [2:0] MODE_AVERAGE = 3'h2;
    localparam logic [2:0] MODE_BURST = 3'h3;
    localparam logic [2:0] MODE_LPF = 3'h4;
    // reset values
    localparam logic [15:0] RST_WORD16 = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } act_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } act_axil_rsp_type;
endpackage

// File: bench/act_compute_regs_assertions.sv
// Purpose: port checks for the compute and threshold register set
// Assumes: one clock, synchronous reset
// Notes: bound to every act_compute_regs instance
`timescale 1ns/1ns
module act_compute_regs_assertions (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire act_pkg::act_axil_req_type axi_req_i,
    input wire act_pkg::act_axil_rsp_type axi_rsp_o,
    input wire logic conv_start_i,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_result_i,
    input wire logic conv_active_o,
    input wire logic threshold_irq_flag_o
);
    // short views of the read channel
    wire logic rv = axi_rsp_o.rvalid;
    wire logic [31:0] rd = axi_rsp_o.rdata;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // converter busy tracking
    property p_start;
        ce_i && conv_start_i && !conv_active_o |=> conv_active_o;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    property p_done;
        ce_i && conv_done_i && conv_active_o |=> !conv_active_o;
    endproperty
    a_done: assert property (p_done)
        else $error("busy after done");
    // flag seen high three samples after the done pulse
    property p_irq;
        $rose(threshold_irq_flag_o) && $past(ce_i) |-> $past(conv_done_i, 3);
    endproperty
    a_irq: assert property (p_irq)
        else $error("flag without check");
    // byte wide read data
    property p_rhi;
        rv |-> rd[31:8] == 24'h00_0000;
    endproperty
    a_rhi: assert property (p_rhi)
        else $error("upper read bits set");
    property p_arr;
        axi_rsp_o.arready == !rv;
    endproperty
    a_arr: assert property (p_arr)
        else $error("arready wrong");
    property p_err;
        rv && axi_rsp_o.rresp == act_pkg::RESP_SLVERR |-> rd == 32'h0000_0000;
    endproperty
    a_err: assert property (p_err)
        else $error("refused read has data");
    property p_rlat;
        ce_i && axi_req_i.arvalid && axi_rsp_o.arready |=> rv;
    endproperty
    a_rlat: assert property (p_rlat)
        else $error("read answer late");
    property p_blat;
        ce_i && axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid;
    endproperty
    a_blat: assert property (p_blat)
        else $error("bvalid stuck");
endmodule // act_compute_regs_assertions
bind act_compute_regs act_compute_regs_assertions
    u_act_compute_regs_assertions (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o),
    .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .conv_active_o(conv_active_o),
    .threshold_irq_flag_o(threshold_irq_flag_o));

// File: bench/act_compute_regs_bench.sv
// Purpose: directed register and converter tests
// Assumes: bready and rready held high
// Notes: byte address is four times the register index
`timescale 1ns/1ns
module act_compute_regs_bench;
    logic mclk_i, sys_rst_i, ce_i, conv_start_i, conv_done_i;
    logic [11:0] conv_result_i;
    logic conv_active_o, threshold_irq_flag_o;
    act_pkg::act_axil_req_type req;
    act_pkg::act_axil_rsp_type rsp;
    int n_fail, n_compared;
    logic [7:0] d, m;
    logic [1:0] r;
    logic [9:0] zi [7] = '{10'h08c, 10'h08d, 10'h08e, 10'h08f, 10'h092,
        10'h093, 10'h09a};
    act_compute_regs u_act_compute_regs (.mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .conv_active_o(conv_active_o),
        .threshold_irq_flag_o(threshold_irq_flag_o));
    // clock
    always #5 mclk_i = ~mclk_i;
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one write, held until taken, waits for response
    task automatic wr(input logic [9:0] i, input logic [7:0] v);
        req.awvalid <= 1'b1;
        req.awaddr <= {i, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h00_0000, v};
        do begin
            @(posedge mclk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        cmp({6'h00, rsp.bresp}, 8'h00);
    endtask
    // waits until the answer; only the watchdog ends a hang
    task automatic rd(input logic [9:0] i);
        req.arvalid <= 1'b1;
        req.araddr <= {i, 2'b00};
        do begin
            @(posedge mclk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata[7:0];
        r = rsp.rresp;
    endtask
    task automatic rchk(input logic [9:0] i, input logic [7:0] e);
        rd(i);
        cmp(d, e);
    endtask
    // converter pulses
    task automatic cstart;
        conv_start_i <= 1'b1;
        @(posedge mclk_i);
        conv_start_i <= 1'b0;
    endtask
    task automatic cdone(input logic [11:0] v);
        conv_done_i <= 1'b1;
        conv_result_i <= v;
        @(posedge mclk_i);
        conv_done_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic conv(input logic [11:0] v);
        cstart;
        cdone(v);
    endtask
    task summarize;
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        n_fail++;
        summarize;
    end
    initial begin
        mclk_i = 1'b0;
        sys_rst_i = 1'b1;
        ce_i = 1'b1;
        conv_start_i = 1'b0;
        conv_done_i = 1'b0;
        conv_result_i = 12'h000;
        req = '0;
        req.wstrb = 4'h1;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        foreach (zi[k]) rchk(zi[k], 8'h00);
        // unmapped index refused, no data
        rd(10'h3ff);
        cmp({6'h00, r}, {6'h00, act_pkg::RESP_SLVERR});
        cmp(d, 8'h00);
        // accumulate mode, sign copies, shifted filter
        wr(10'h0a1, 8'h30);
        wr(10'h096, 8'h00);
        wr(10'h097, 8'h00);
        wr(10'h098, 8'h03);
        rchk(10'h098, 8'hff);
        wr(10'h098, 8'h00);
        conv(12'h123);
        rchk(10'h094, 8'h23);
        rchk(10'h095, 8'h01);
        cstart;
        wr(10'h096, 8'h55);
        cmp(8'(conv_active_o), 8'h01);
        cdone(12'h010);
        rchk(10'h096, 8'h33);
        rchk(10'h09b, 8'h23);
        rchk(10'h09c, 8'h01);
        rchk(10'h09d, 8'h10);
        wr(10'h0a1, 8'h2a);
        rchk(10'h094, 8'h4c);
        conv(12'habc);
        rchk(10'h09e, 8'hab);
        rchk(10'h09d, 8'hc0);
        rchk(10'h09b, 8'h4c);
        // every irq select, error above and at lower
        wr(10'h0a1, 8'h10);
        wr(10'h08d, 8'hff);
        wr(10'h08f, 8'h01);
        for (int c = 0; c < 2; c++) begin
            wr(10'h093, c ? 8'h03 : 8'h00);
            m = c ? 8'hac : 8'hd4;
            for (int s = 0; s < 8; s++) begin
                wr(10'h0a0, 8'h10 | 8'(s));
                wr(10'h0a2, 8'h04);
                conv(12'h200);
                cmp(8'(threshold_irq_flag_o), 8'(m[s]));
            end
            rchk(10'h0a2, c ? 8'h04 : 8'h06);
            rchk(10'h091, c ? 8'hff : 8'h02);
        end
        // average then burst mode, check on third trigger
        for (int b = 0; b < 2; b++) begin
            wr(10'h0a1, b ? 8'h70 : 8'h50);
            wr(10'h09a, 8'h03);
            wr(10'h099, 8'h00);
            wr(10'h0a2, 8'h04);
            for (int k = 1; k < 4; k++) begin
                conv(12'h001);
                cmp(8'(threshold_irq_flag_o), 8'(k == 3));
            end
        end
        // start pulse ignored while frozen
        ce_i <= 1'b0;
        cstart;
        ce_i <= 1'b1;
        @(posedge mclk_i);
        cmp(8'(conv_active_o), 8'h00);
        // low-pass mode, half step toward each sample
        wr(10'h0a1, 8'h91);
        conv(12'h100);
        rchk(10'h094, 8'h80);
        conv(12'h100);
        rchk(10'h094, 8'hc0);
        // mid-run reset keeps the repeat counter
        wr(10'h099, 8'h5a);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        rchk(10'h099, 8'h5a);
        rchk(10'h08d, 8'h00);
        summarize;
    end
endmodule // act_compute_regs_bench
